// ===== core/lpw_pkg.sv
// Shared constants and types for the low-power wake control block
package lpw_pkg;

  // ==========================================================================
  // Wake sources and vectors
  // ==========================================================================
  localparam int SRC_N = 22;
  localparam logic [4:0] SRC_RESET_IDX = 5'h00;
  localparam logic [4:0] SRC_IRQ_IDX = 5'h02;
  // Index 0 has the highest priority; each entry is the high byte of a pair
  localparam logic [15:0] VEC_TABLE [SRC_N] = '{
    16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8,
    16'hFFF6, 16'hFFF4, 16'hFFF2,
    16'hFFF0, 16'hFFEE, 16'hFFEC,
    16'hFFEA, 16'hFFE8,
    16'hFFE6, 16'hFFE4, 16'hFFE2,
    16'hFFE0, 16'hFFDE, 16'hFFDC,
    16'hFFDA, 16'hFFD8, 16'hFFD6, 16'hFFD4
  };

  // ==========================================================================
  // Pin synchroniser lanes
  // ==========================================================================
  localparam int PIN_N     = 5;
  localparam int PIN_RST   = 0;
  localparam int PIN_IRQ   = 1;
  localparam int PIN_KBD   = 2;
  localparam int PIN_CANRX = 3;
  localparam int PIN_XTAL  = 4;
  localparam logic [PIN_N-1:0] PIN_IDLE = 5'h0F;

  // ==========================================================================
  // Stop recovery
  // ==========================================================================
  localparam int REC_W         = 12;
  localparam int REC_LONG_CYC  = 4096;
  localparam int REC_SHORT_CYC = 32;

  // ==========================================================================
  // Reset values of control outputs
  // ==========================================================================
  localparam logic CLK_EN_RST = 1'b1;
  localparam logic RUN_RST    = 1'b1;
  localparam logic [15:0] VEC_RST = 16'hFFFE;

  typedef enum logic [1:0] {LPW_RUN, LPW_WAIT, LPW_STOP, LPW_RECOVER} lpw_mode_t;

  typedef struct packed {
    lpw_mode_t        mode;
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic             cpu_clk_en;
    logic             sys_clk_en;
    logic [15:0]      vec;
    logic             vec_load;
    logic             reset_exit;
    logic             spi_run;
    logic             spi_rst;
    logic             tim_run;
    logic             pwt_run;
    logic             pwt_access;
    logic             can_run;
    logic             can_access;
    logic             can_rx_en;
    logic             can_invalid;
    logic             rec_start;
    logic             rec_short;
    logic             xtal_tick;
    logic             wait_mode;
    logic             stop_mode;
  } lpw_ctrl_t;

  typedef struct packed {
    logic             busy;
    logic             short_sel;
    logic [REC_W-1:0] cnt;
    logic             done;
  } lpw_rec_t;

endpackage : lpw_pkg

// ===== core/lpw_rec_if.sv
// Link between the wake controller and its stop recovery counter
`timescale 1ns/10ps
interface lpw_rec_if;
  logic start;
  logic short_sel;
  logic tick;
  logic done;
  modport ctrl (output start, output short_sel, output tick, input done);
  modport cnt  (input start, input short_sel, input tick, output done);
endinterface : lpw_rec_if

// ===== core/lpw_recovery.sv
// Stop recovery counter clocked by clk and advanced by crystal clock ticks
`timescale 1ns/10ps
module lpw_recovery (
  input wire logic clk,
  input wire logic reset,
  lpw_rec_if.cnt   rif
);

  lpw_pkg::lpw_rec_t q;
  lpw_pkg::lpw_rec_t d;
  logic [lpw_pkg::REC_W-1:0] last;

  assign rif.done = q.done;

  // ==========================================================================
  // Counter
  // ==========================================================================
  always_comb begin
    d = q;
    d.done = 1'b0;
    last = q.short_sel ? lpw_pkg::REC_W'(lpw_pkg::REC_SHORT_CYC - 1)
                       : lpw_pkg::REC_W'(lpw_pkg::REC_LONG_CYC - 1);
    if (rif.start) begin
      d.busy = 1'b1;
      d.cnt = '0;
      d.short_sel = rif.short_sel;
    end else if (q.busy && rif.tick) begin
      if (q.cnt == last) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_start_zero;
    @(posedge clk) disable iff (reset)
    rif.start |=> (q.busy && q.cnt == 12'h000);
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("Recovery did not start at zero");

  property p_done_at_last;
    @(posedge clk) disable iff (reset)
    q.done |-> ($past(q.cnt) == (q.short_sel ? 12'h01F : 12'hFFF)) && !q.busy;
  endproperty
  a_done_at_last: assert property (p_done_at_last) else $error("Recovery ended at wrong count");

endmodule : lpw_recovery

// ===== core/lpw_wake_ctrl.sv
// Wait and stop mode supervision with wake vectoring and stop recovery
`timescale 1ns/10ps
module lpw_wake_ctrl (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wait_exec,
  input  wire logic        stop_exec,
  input  wire logic        short_recovery_bit,
  input  wire logic        oscillator_on_in_stop_bit,
  input  wire logic        emu_mode,
  input  wire logic        reset_pin_n,
  input  wire logic        irq_pin_n,
  input  wire logic        keypad_pin_n,
  input  wire logic        can_rx_pin,
  input  wire logic        crystal_clock,
  input  wire logic        watchdog_timeout,
  input  wire logic        low_voltage_trip,
  input  wire logic        break_irq,
  input  wire logic        clkgen_irq,
  input  wire logic        keypad_irq,
  input  wire logic [2:0]  timer_unit_one_irq,
  input  wire logic [2:0]  timer_unit_two_irq,
  input  wire logic [1:0]  spi_irq,
  input  wire logic [2:0]  sci_irq,
  input  wire logic        adc_irq,
  input  wire logic        pwt_irq,
  input  wire logic [3:0]  can_irq,
  input  wire logic        can_busy,
  output logic             cpu_clk_en,
  output logic             sys_clk_en,
  output logic [15:0]      vector_addr,
  output logic             vector_load,
  output logic             in_wait,
  output logic             in_stop,
  output logic             spi_run,
  output logic             spi_reset,
  output logic             tim_run,
  output logic             pwt_run,
  output logic             pwt_access_en,
  output logic             can_run,
  output logic             can_access_en,
  output logic             can_rx_en,
  output logic             can_data_invalid
);

  lpw_pkg::lpw_ctrl_t   q;
  lpw_pkg::lpw_ctrl_t   d;
  logic [lpw_pkg::SRC_N-1:0] wreq;
  logic [lpw_pkg::SRC_N-1:0] sreq;
  logic [lpw_pkg::PIN_N-1:0] fall;
  logic                  rst_req;
  logic                  stopped;
  logic [15:0]           wvec;
  logic [15:0]           svec;
  logic                  wrst;
  logic                  srst;

  lpw_rec_if rec ();

  lpw_recovery u_recovery (
    .clk   (clk),
    .reset (reset),
    .rif   (rec)
  );

  assign rec.start     = q.rec_start;
  assign rec.short_sel = q.rec_short;
  assign rec.tick      = q.xtal_tick;

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign cpu_clk_en       = q.cpu_clk_en;
  assign sys_clk_en       = q.sys_clk_en;
  assign vector_addr      = q.vec;
  assign vector_load      = q.vec_load;
  assign in_wait          = q.wait_mode;
  assign in_stop          = q.stop_mode;
  assign spi_run          = q.spi_run;
  assign spi_reset        = q.spi_rst;
  assign tim_run          = q.tim_run;
  assign pwt_run          = q.pwt_run;
  assign pwt_access_en    = q.pwt_access;
  assign can_run          = q.can_run;
  assign can_access_en    = q.can_access;
  assign can_rx_en        = q.can_rx_en;
  assign can_data_invalid = q.can_invalid;

  // ==========================================================================
  // Wake requests, index 0 highest priority
  // ==========================================================================
  // Edges read only the second and third stages, never the first
  assign fall    = q.s3 & ~q.s2;
  assign rst_req = ~q.s2[lpw_pkg::PIN_RST] | low_voltage_trip;

  assign wreq = {can_irq, pwt_irq, adc_irq, keypad_irq, sci_irq, spi_irq,
                 timer_unit_two_irq, timer_unit_one_irq, clkgen_irq,
                 fall[lpw_pkg::PIN_IRQ], break_irq & emu_mode,
                 rst_req | watchdog_timeout};

  // Watchdog has no clock in stop, so it is not a stop exit
  assign sreq = {3'h0, fall[lpw_pkg::PIN_CANRX],
                 pwt_irq & oscillator_on_in_stop_bit, 1'b0,
                 keypad_irq | fall[lpw_pkg::PIN_KBD], 12'h000,
                 fall[lpw_pkg::PIN_IRQ], 1'b0, rst_req};

  always_comb begin
    wvec = lpw_pkg::VEC_TABLE[0];
    svec = lpw_pkg::VEC_TABLE[0];
    wrst = 1'b0;
    srst = 1'b0;
    for (int i = lpw_pkg::SRC_N - 1; i >= 0; i--) begin
      if (wreq[i]) begin
        wvec = lpw_pkg::VEC_TABLE[i];
        wrst = (i == 0);
      end
      if (sreq[i]) begin
        svec = lpw_pkg::VEC_TABLE[i];
        srst = (i == 0);
      end
    end
  end

  // ==========================================================================
  // Mode sequencing
  // ==========================================================================
  always_comb begin
    d = q;
    d.s1 = {crystal_clock, can_rx_pin, keypad_pin_n, irq_pin_n, reset_pin_n};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.xtal_tick = fall[lpw_pkg::PIN_XTAL] ? 1'b0 : (q.s2[lpw_pkg::PIN_XTAL] & ~q.s3[lpw_pkg::PIN_XTAL]);
    d.vec_load = 1'b0;
    d.spi_rst = 1'b0;
    d.can_invalid = 1'b0;
    d.rec_start = 1'b0;
    case (q.mode)
      lpw_pkg::LPW_RUN: begin
        if (stop_exec) begin
          d.mode = lpw_pkg::LPW_STOP;
          d.cpu_clk_en = 1'b0;
          d.sys_clk_en = oscillator_on_in_stop_bit;
          d.can_invalid = can_busy;
        end else if (wait_exec) begin
          d.mode = lpw_pkg::LPW_WAIT;
          d.cpu_clk_en = 1'b0;
          d.sys_clk_en = 1'b1;
        end
      end
      lpw_pkg::LPW_WAIT: begin
        if (|wreq) begin
          d.mode = lpw_pkg::LPW_RUN;
          d.cpu_clk_en = 1'b1;
          d.vec = wvec;
          d.vec_load = 1'b1;
          d.reset_exit = wrst;
        end
      end
      lpw_pkg::LPW_STOP: begin
        if (|sreq) begin
          d.mode = lpw_pkg::LPW_RECOVER;
          d.sys_clk_en = 1'b0;
          d.vec = svec;
          d.reset_exit = srst;
          d.spi_rst = srst;
          d.rec_start = 1'b1;
          d.rec_short = short_recovery_bit;
        end
      end
      lpw_pkg::LPW_RECOVER: begin
        if (rec.done) begin
          d.mode = lpw_pkg::LPW_RUN;
          d.cpu_clk_en = 1'b1;
          d.sys_clk_en = 1'b1;
          d.vec_load = 1'b1;
        end
      end
      default: begin
        d.mode = lpw_pkg::LPW_RUN;
      end
    endcase
    stopped = (d.mode == lpw_pkg::LPW_STOP) || (d.mode == lpw_pkg::LPW_RECOVER);
    d.spi_run = !stopped;
    d.tim_run = !stopped;
    d.can_run = !stopped;
    d.pwt_run = !stopped || oscillator_on_in_stop_bit;
    d.pwt_access = (d.mode == lpw_pkg::LPW_RUN);
    d.can_access = (d.mode == lpw_pkg::LPW_RUN);
    d.can_rx_en = !stopped;
    d.wait_mode = (d.mode == lpw_pkg::LPW_WAIT);
    d.stop_mode = stopped;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '{mode: lpw_pkg::LPW_RUN, s1: lpw_pkg::PIN_IDLE, s2: lpw_pkg::PIN_IDLE,
             s3: lpw_pkg::PIN_IDLE, cpu_clk_en: lpw_pkg::CLK_EN_RST,
             sys_clk_en: lpw_pkg::CLK_EN_RST, vec: lpw_pkg::VEC_RST,
             spi_run: lpw_pkg::RUN_RST, tim_run: lpw_pkg::RUN_RST,
             pwt_run: lpw_pkg::RUN_RST, pwt_access: lpw_pkg::RUN_RST,
             can_run: lpw_pkg::RUN_RST, can_access: lpw_pkg::RUN_RST,
             can_rx_en: lpw_pkg::RUN_RST, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_wait_clocks;
    q.mode == lpw_pkg::LPW_WAIT |-> q.sys_clk_en && !q.cpu_clk_en;
  endproperty
  a_wait_clocks: assert property (p_wait_clocks) else $error("Wait clock gating wrong");

  property p_wait_units_run;
    q.mode == lpw_pkg::LPW_WAIT |-> q.spi_run && q.tim_run && q.pwt_run && q.can_run;
  endproperty
  a_wait_units_run: assert property (p_wait_units_run) else $error("Unit halted in wait");

  property p_stop_units_halt;
    in_stop |-> !q.spi_run && !q.tim_run && !q.can_run;
  endproperty
  a_stop_units_halt: assert property (p_stop_units_halt) else $error("Unit running in stop");

  property p_no_access_low_power;
    q.mode != lpw_pkg::LPW_RUN |-> !q.pwt_access && !q.can_access;
  endproperty
  a_no_access_low_power: assert property (p_no_access_low_power) else $error("Access open");

  property p_pwt_stop_osc;
    (q.mode == lpw_pkg::LPW_STOP) && $past(q.mode == lpw_pkg::LPW_STOP)
      |-> q.pwt_run == $past(oscillator_on_in_stop_bit);
  endproperty
  a_pwt_stop_osc: assert property (p_pwt_stop_osc) else $error("Wake timer stop state wrong");

  property p_reset_vec;
    (q.mode == lpw_pkg::LPW_WAIT) && wreq[0] |=> q.vec_load && q.vec == 16'hFFFE && q.cpu_clk_en;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("Reset wake vector wrong");

  property p_irq_vec;
    (q.mode == lpw_pkg::LPW_WAIT) && wreq[2:0] == 3'b100 |=> q.vec == 16'hFFFA;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("Interrupt wake vector wrong");

  property p_stop_only_listed;
    (q.mode == lpw_pkg::LPW_STOP) && !(|sreq) |=> q.mode == lpw_pkg::LPW_STOP;
  endproperty
  a_stop_only_listed: assert property (p_stop_only_listed) else $error("Stop left without cause");

  property p_recover_hold;
    q.mode == lpw_pkg::LPW_RECOVER |-> !q.sys_clk_en && !q.cpu_clk_en && !q.can_rx_en;
  endproperty
  a_recover_hold: assert property (p_recover_hold) else $error("Clocks released early");

  property p_spi_reset_exit;
    (q.mode == lpw_pkg::LPW_STOP) && sreq[0] |=> q.spi_rst ##1 !q.spi_rst;
  endproperty
  a_spi_reset_exit: assert property (p_spi_reset_exit) else $error("SPI not reset on exit");

  property p_spi_rst_cause;
    q.spi_rst |-> q.reset_exit && q.vec == 16'hFFFE;
  endproperty
  a_spi_rst_cause: assert property (p_spi_rst_cause) else $error("SPI reset cause wrong");

  property p_recover_release;
    (q.mode == lpw_pkg::LPW_RECOVER) && rec.done
      |=> q.mode == lpw_pkg::LPW_RUN && q.vec_load && q.cpu_clk_en && q.sys_clk_en;
  endproperty
  a_recover_release: assert property (p_recover_release) else $error("Release wrong");

  property p_can_drop;
    (q.mode == lpw_pkg::LPW_RUN) && stop_exec && can_busy |=> q.can_invalid;
  endproperty
  a_can_drop: assert property (p_can_drop) else $error("CAN data kept");

  property p_pwt_stop_vec;
    (q.mode == lpw_pkg::LPW_STOP) && sreq[17:0] == 18'h20000 |=> q.vec == 16'hFFDC;
  endproperty
  a_pwt_stop_vec: assert property (p_pwt_stop_vec) else $error("Timer vector wrong");

  property p_kbd_stop_vec;
    (q.mode == lpw_pkg::LPW_STOP) && sreq[15:0] == 16'h8000 |=> q.vec == 16'hFFE0;
  endproperty
  a_kbd_stop_vec: assert property (p_kbd_stop_vec) else $error("Keypad vector wrong");

endmodule : lpw_wake_ctrl

// ===== bench/lpw_xtal_model.sv
// Crystal oscillator stand-in that supplies stop recovery ticks
`timescale 1ns/10ps
module lpw_xtal_model #(
  parameter int HALF = 5
) (
  input  wire logic        clk,
  input  wire logic        run,
  output logic             crystal_clock,
  output logic [15:0]      ticks
);
  int ph;

  initial begin
    crystal_clock = 1'b0;
    ticks = 16'h0000;
    ph = 0;
  end

  // Held low while stopped so no stray tick lands before counting starts
  always @(posedge clk) begin
    if (!run) begin
      crystal_clock <= 1'b0;
      ticks <= 16'h0000;
      ph <= 0;
    end else if (ph == HALF - 1) begin
      ph <= 0;
      crystal_clock <= ~crystal_clock;
      if (!crystal_clock) begin
        ticks <= ticks + 16'h0001;
      end
    end else begin
      ph <= ph + 1;
    end
  end
endmodule : lpw_xtal_model

// ===== bench/testbench.sv
// Self-checking bench for the low-power wake controller
`timescale 1ns/10ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic clk = 1'b0, reset = 1'b1, wait_exec = 1'b0, stop_exec = 1'b0;
  logic short_recovery_bit = 1'b1, oscillator_on_in_stop_bit = 1'b0, emu_mode = 1'b1;
  logic reset_pin_n = 1'b1, irq_pin_n = 1'b1, keypad_pin_n = 1'b1, can_rx_pin = 1'b1;
  logic low_voltage_trip = 1'b0, can_busy = 1'b0, xrun = 1'b0, crystal_clock;
  logic [21:0] r = '0;
  logic [15:0] ticks, vector_addr;
  logic cpu_clk_en, sys_clk_en, vector_load, in_wait, in_stop, spi_run, spi_reset;
  logic tim_run, pwt_run, pwt_access_en, can_run, can_access_en, can_rx_en, can_data_invalid;
  int fail_count = 0, check_count = 0;
  // Request bit k maps to the source whose vector is FFFE - 2k
  wire watchdog_timeout = r[0];
  wire break_irq = r[1];
  wire clkgen_irq = r[3];
  wire [2:0] timer_unit_one_irq = r[6:4];
  wire [2:0] timer_unit_two_irq = r[9:7];
  wire [1:0] spi_irq = {r[11], r[10]};
  wire [2:0] sci_irq = {r[14], r[13], r[12]};
  wire keypad_irq = r[15];
  wire adc_irq = r[16];
  wire pwt_irq = r[17];
  wire [3:0] can_irq = r[21:18];

  always #10 clk = ~clk;

  lpw_xtal_model #(.HALF(5)) lpw_xtal_model_inst (.clk, .run(xrun), .crystal_clock, .ticks);

  lpw_wake_ctrl lpw_wake_ctrl_inst (.clk, .reset, .wait_exec, .stop_exec, .short_recovery_bit,
    .oscillator_on_in_stop_bit, .emu_mode, .reset_pin_n, .irq_pin_n, .keypad_pin_n,
    .can_rx_pin, .crystal_clock, .watchdog_timeout, .low_voltage_trip, .break_irq,
    .clkgen_irq, .keypad_irq, .timer_unit_one_irq, .timer_unit_two_irq, .spi_irq, .sci_irq, .adc_irq, .pwt_irq,
    .can_irq, .can_busy, .cpu_clk_en, .sys_clk_en, .vector_addr, .vector_load, .in_wait,
    .in_stop, .spi_run, .spi_reset, .tim_run, .pwt_run, .pwt_access_en, .can_run,
    .can_access_en, .can_rx_en, .can_data_invalid);

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic results;
    $display("Checks %0d, errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic enter_mode(input logic stop);
    @(posedge clk);
    if (stop) stop_exec <= 1'b1;
    else wait_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    wait_exec <= 1'b0;
    #1;
  endtask : enter_mode

  task automatic wait_vl(input int max);
    for (int i = 0; i < max && vector_load !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_vl

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    `CHK({cpu_clk_en, sys_clk_en, vector_load, in_wait, in_stop}, 5'h18);
    `CHK(vector_addr, 16'hFFFE);
    `CHK({pwt_access_en, can_access_en, can_rx_en}, 3'h7);
  endtask : t_reset

  task automatic t_wait_table;
    for (int k = 0; k < 22; k++) begin
      if (k != 2) begin
        enter_mode(1'b0);
        `CHK({in_wait, cpu_clk_en, pwt_access_en, can_access_en}, 4'h8);
        `CHK({spi_run, tim_run, pwt_run, can_run, sys_clk_en}, 5'h1F);
        @(posedge clk);
        r <= 22'h1 << k;
        @(posedge clk);
        #1;
        `CHK({vector_load, cpu_clk_en, in_wait}, 3'h6);
        `CHK(vector_addr, 16'hFFFE - 16'(2 * k));
        @(posedge clk);
        r <= '0;
      end
    end
  endtask : t_wait_table

  task automatic t_wait_misc;
    emu_mode <= 1'b0;
    enter_mode(1'b0);
    @(posedge clk);
    r <= 22'h2;
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK({in_wait, in_stop}, 2'h2);
    @(posedge clk);
    r <= 22'h20202;
    @(posedge clk);
    #1;
    `CHK(vector_addr, 16'hFFEC);
    @(posedge clk);
    r <= '0;
    enter_mode(1'b0);
    @(posedge clk);
    irq_pin_n <= 1'b0;
    wait_vl(10);
    `CHK({vector_load, vector_addr}, 17'h1FFFA);
    @(posedge clk);
    irq_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : t_wait_misc

  task automatic t_stop(input int kind, input logic sh, input logic osc,
                        input logic [15:0] exp, input logic [15:0] nt);
    logic seen, held;
    seen = 1'b0;
    held = 1'b0;
    short_recovery_bit <= sh;
    oscillator_on_in_stop_bit <= osc;
    can_busy <= (kind == 4);
    enter_mode(1'b1);
    `CHK({in_stop, cpu_clk_en, spi_run, tim_run, can_run}, 5'h10);
    `CHK({sys_clk_en, pwt_run, pwt_access_en}, {osc, osc, 1'b0});
    `CHK(can_data_invalid, kind == 4);
    // Watchdog, timer and (without oscillator) wake timer must not end stop
    @(posedge clk);
    r <= osc ? 22'h11 : 22'h20011;
    repeat (5) @(posedge clk);
    r <= '0;
    #1;
    `CHK({in_stop, vector_load}, 2'h2);
    @(posedge clk);
    case (kind)
      0: irq_pin_n <= 1'b0;
      1: reset_pin_n <= 1'b0;
      2: keypad_pin_n <= 1'b0;
      3: r <= 22'h20000;
      4: can_rx_pin <= 1'b0;
      default: low_voltage_trip <= 1'b1;
    endcase
    // Reset pulse comes early in recovery, so watch it here too
    repeat (6) begin
      @(negedge clk);
      if (spi_reset === 1'b1) seen = 1'b1;
    end
    @(posedge clk);
    {irq_pin_n, reset_pin_n, keypad_pin_n, can_rx_pin, low_voltage_trip} <= 5'h1E;
    r <= '0;
    xrun <= 1'b1;
    #1;
    `CHK({in_stop, can_rx_en}, 2'h2);
    for (int n = 0; n < 45000 && vector_load !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      if (spi_reset === 1'b1) seen = 1'b1;
      if (vector_load !== 1'b1 && cpu_clk_en !== 1'b0) held = 1'b1;
    end
    `CHK({held, ticks}, {1'b0, nt});
    `CHK({vector_load, vector_addr}, {1'b1, exp});
    `CHK(seen, kind == 1 || kind == 5);
    `CHK({cpu_clk_en, sys_clk_en, can_rx_en, tim_run, spi_run}, 5'h1F);
    @(posedge clk);
    xrun <= 1'b0;
    can_busy <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : t_stop

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_wait_table();
    t_wait_misc();
    t_stop(0, 1'b1, 1'b0, 16'hFFFA, 16'd32);
    t_stop(1, 1'b0, 1'b0, 16'hFFFE, 16'd4096);
    t_stop(2, 1'b1, 1'b0, 16'hFFE0, 16'd32);
    t_stop(3, 1'b1, 1'b1, 16'hFFDC, 16'd32);
    t_stop(4, 1'b1, 1'b1, 16'hFFDA, 16'd32);
    t_stop(5, 1'b1, 1'b0, 16'hFFFE, 16'd32);
    results();
  end

  initial begin
    #1_200_000;
    fail_count++;
    results();
  end
endmodule : testbench
